// *** src/pieb_regs.svh ***
`ifndef PIEB_REGS_SVH
`define PIEB_REGS_SVH

// Register offsets on the plain register port
`define PIEB_OFF_EN1   4'h0
`define PIEB_OFF_EN2   4'h1
`define PIEB_OFF_EN3   4'h2
`define PIEB_OFF_EN4   4'h3
`define PIEB_OFF_EN5   4'h4
`define PIEB_OFF_CTRL  4'h5
`define PIEB_OFF_STAT  4'h6
`define PIEB_OFF_MASK  4'h7

// Reset values
`define PIEB_RST_EN    8'h00
`define PIEB_RST_CTRL  8'h00
`define PIEB_RST_BANK  5'h00

// Implemented bits per enable register, full and small memory variant
`define PIEB_IMPL_EN1      8'hff
`define PIEB_IMPL_EN2      8'hbf
`define PIEB_IMPL_EN3      8'hbf
`define PIEB_IMPL_EN4      8'hff
`define PIEB_IMPL_EN5      8'hff
`define PIEB_IMPL_EN4_32K  8'h3f
`define PIEB_IMPL_EN5_32K  8'h17

// First enable register fields
`define PIEB_PARALLEL_PORT_IRQ_EN    7
`define PIEB_ADC_DONE_IRQ_EN         6
`define PIEB_SERIAL1_RX_IRQ_EN       5
`define PIEB_SERIAL1_TX_IRQ_EN       4
`define PIEB_SYNC_SERIAL1_IRQ_EN     3
`define PIEB_TIMER1_GATE_IRQ_EN      2
`define PIEB_TIMER2_MATCH_IRQ_EN     1
`define PIEB_TIMER1_OVERFLOW_IRQ_EN  0
// Second enable register fields
`define PIEB_OSC_FAIL_IRQ_EN         7
`define PIEB_SYNC_SERIAL2_IRQ_EN     5
`define PIEB_BUS_COLLISION2_IRQ_EN   4
`define PIEB_BUS_COLLISION1_IRQ_EN   3
`define PIEB_VOLTAGE_DETECT_IRQ_EN   2
`define PIEB_TIMER3_OVERFLOW_IRQ_EN  1
`define PIEB_TIMER3_GATE_IRQ_EN      0
// Third enable register fields
`define PIEB_TIMER5_GATE_IRQ_EN      7
`define PIEB_SERIAL2_RX_IRQ_EN       5
`define PIEB_SERIAL2_TX_IRQ_EN       4
`define PIEB_CHARGE_TIME_IRQ_EN      3
`define PIEB_CAPCOMP2_IRQ_EN         2
`define PIEB_CAPCOMP1_IRQ_EN         1
`define PIEB_RTC_IRQ_EN              0
// Fourth register: capture/compare 10..3 on bits 7..0
`define PIEB_CAPCOMP_10_TO_3_IRQ_EN  0
// Fifth enable register fields
`define PIEB_TIMER7_GATE_IRQ_EN      7
`define PIEB_TIMER12_MATCH_IRQ_EN    6
`define PIEB_TIMER10_MATCH_IRQ_EN    5
`define PIEB_TIMER8_MATCH_IRQ_EN     4
`define PIEB_TIMER7_OVERFLOW_IRQ_EN  3
`define PIEB_TIMER6_MATCH_IRQ_EN     2
`define PIEB_TIMER5_OVERFLOW_IRQ_EN  1
`define PIEB_TIMER4_MATCH_IRQ_EN     0

// Control register fields
`define PIEB_PERIPHERAL_GROUP_IRQ_EN 0
`define PIEB_IRQ_PRIORITY_ENABLE     7

`endif

// *** src/pieb_pkg.sv ***
package pieb_pkg;

  // One enable register, one byte of flags
  typedef logic [7:0] pieb_byte_t;

  // One bit per enable register, for status and mask
  typedef logic [4:0] pieb_bank_t;

  // Register port address
  typedef logic [3:0] pieb_addr_t;

endpackage : pieb_pkg

// *** src/pieb_bank.sv ***
`timescale 1ns/100ps
`include "pieb_regs.svh"

// Overview of operation
// - Enable register one holds, bit 7 to 0, parallel port, ADC, serial1 rx, serial1 tx, sync serial1, timer1 gate, timer2 match, timer1 overflow.
// - A source's request passes when its enable bit is 1 and is blocked when it is 0.
// - All implemented enable bits of the five registers are 0 after reset.
// - Enable register two holds osc fail at 7, sync serial2 at 5, collision2 at 4, collision1 at 3, voltage detect at 2, timer3 overflow at 1, timer3 gate at 0.
// - Bit 6 of enable registers two and three always reads 0 and ignores writes.
// - Enable register three holds timer5 gate at 7, serial2 rx at 5, serial2 tx at 4, charge time at 3, capcomp2 at 2, capcomp1 at 1, rtc at 0.
// - Enable register four holds capture/compare 10 at bit 7 down to 3 at bit 0.
// - The small memory variant drops capcomp 10 and 9 and timer7 gate, timer12, timer10 and timer7 overflow enables.
// - Enable register five holds, bit 7 to 0, timer7 gate, timer12, timer10, timer8, timer7 overflow, timer6, timer5 overflow, timer4.
// - With priority mode off, the group enable must be set before periph_irq_o raises a request; gated_o passes requests without it.
module pieb_bank #(
  parameter int unsigned NUM_EN       = 5,
  parameter bit          PROG_MEM_32K = 1'b0
) (
  // Clock and reset
  input  wire logic                clk_i,
  input  wire logic                sys_rst_i,
  // Register port
  input  wire pieb_pkg::pieb_addr_t addr_i,
  input  wire pieb_pkg::pieb_byte_t wdata_i,
  input  wire logic                wr_i,
  input  wire logic                rd_i,
  output      pieb_pkg::pieb_byte_t rdata_o,
  // Peripheral flags, byte n pairs with enable register n+1
  input  wire logic [39:0]         flags_i,
  // Gated requests toward the core
  output      logic [39:0]         gated_o,
  output      logic                periph_irq_o,
  // Bank interrupt
  output      logic                irq_o
);

  // The flag vector and status layout assume exactly five registers
  if (NUM_EN != 5) begin : g_check
    $error("pieb_bank serves exactly five enable registers");
  end

  // Implemented bits of enable register idx
  function automatic pieb_pkg::pieb_byte_t impl_mask(
    input int unsigned idx,
    input bit          small_mem
  );
    pieb_pkg::pieb_byte_t m;
    m = `PIEB_IMPL_EN1;
    unique case (idx)
      0: m = `PIEB_IMPL_EN1;
      1: m = `PIEB_IMPL_EN2;
      2: m = `PIEB_IMPL_EN3;
      3: m = small_mem ? `PIEB_IMPL_EN4_32K
                   : `PIEB_IMPL_EN4;
      4: m = small_mem ? `PIEB_IMPL_EN5_32K
                   : `PIEB_IMPL_EN5;
      default: m = 8'h00;
    endcase
    return m;
  endfunction : impl_mask

  // Offset of enable register idx
  function automatic pieb_pkg::pieb_addr_t en_off(
    input int unsigned idx
  );
    pieb_pkg::pieb_addr_t a;
    a = 4'(idx) + `PIEB_OFF_EN1;
    return a;
  endfunction : en_off

  // Storage
  pieb_pkg::pieb_byte_t en_q [NUM_EN];
  pieb_pkg::pieb_byte_t ctrl_q;
  pieb_pkg::pieb_bank_t stat_q;
  pieb_pkg::pieb_bank_t stat_d;
  pieb_pkg::pieb_bank_t mask_q;
  pieb_pkg::pieb_bank_t bank_hit;
  pieb_pkg::pieb_bank_t stat_clr;
  pieb_pkg::pieb_byte_t rdata_q;
  pieb_pkg::pieb_byte_t rdata_d;
  logic [39:0]          gated_d;
  logic [39:0]          gated_q;
  logic                 periph_q;
  logic                 group_ok;
  logic [39:0]          en_vec;
  // Named enables of register one
  logic                 parallel_port_irq_en;
  logic                 adc_done_irq_en;
  logic                 serial1_rx_irq_en;
  logic                 serial1_tx_irq_en;
  logic                 sync_serial1_irq_en;
  logic                 timer1_gate_irq_en;
  logic                 timer2_match_irq_en;
  logic                 timer1_overflow_irq_en;
  // Named enables of register two
  logic                 osc_fail_irq_en;
  logic                 sync_serial2_irq_en;
  logic                 bus_collision2_irq_en;
  logic                 bus_collision1_irq_en;
  logic                 voltage_detect_irq_en;
  logic                 timer3_overflow_irq_en;
  logic                 timer3_gate_irq_en;
  // Named enables of register three
  logic                 timer5_gate_irq_en;
  logic                 serial2_rx_irq_en;
  logic                 serial2_tx_irq_en;
  logic                 charge_time_irq_en;
  logic                 capcomp2_irq_en;
  logic                 capcomp1_irq_en;
  logic                 rtc_irq_en;
  // Named enables of register four
  logic [7:0]           capcomp_10_to_3_irq_en;
  // Named enables of register five
  logic                 timer7_gate_irq_en;
  logic                 timer12_match_irq_en;
  logic                 timer10_match_irq_en;
  logic                 timer8_match_irq_en;
  logic                 timer7_overflow_irq_en;
  logic                 timer6_match_irq_en;
  logic                 timer5_overflow_irq_en;
  logic                 timer4_match_irq_en;

  // Enable registers; unimplemented bits never store a one
  for (genvar n = 0; n < NUM_EN; n++) begin : g_en
    always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
        en_q[n] <= `PIEB_RST_EN;
      end else if (wr_i && addr_i == en_off(n)) begin
        en_q[n] <= wdata_i & impl_mask(n, PROG_MEM_32K);
      end
    end

    // Gate each flag by its named enable and by the bits that exist
    assign gated_d[n*8 +: 8] = flags_i[n*8 +: 8]
                             & en_vec[n*8 +: 8]
                             & impl_mask(n, PROG_MEM_32K);

    // A bank counts as hit while any of its gated requests stands
    assign bank_hit[n] = |gated_d[n*8 +: 8];
  end

  // Named view of register one; stored bits are already masked
  assign parallel_port_irq_en = en_q[0][`PIEB_PARALLEL_PORT_IRQ_EN];
  assign adc_done_irq_en = en_q[0][`PIEB_ADC_DONE_IRQ_EN];
  assign serial1_rx_irq_en = en_q[0][`PIEB_SERIAL1_RX_IRQ_EN];
  assign serial1_tx_irq_en = en_q[0][`PIEB_SERIAL1_TX_IRQ_EN];
  assign sync_serial1_irq_en = en_q[0][`PIEB_SYNC_SERIAL1_IRQ_EN];
  assign timer1_gate_irq_en = en_q[0][`PIEB_TIMER1_GATE_IRQ_EN];
  assign timer2_match_irq_en = en_q[0][`PIEB_TIMER2_MATCH_IRQ_EN];
  assign timer1_overflow_irq_en = en_q[0][`PIEB_TIMER1_OVERFLOW_IRQ_EN];
  // Register two; bit 6 has no storage
  assign osc_fail_irq_en = en_q[1][`PIEB_OSC_FAIL_IRQ_EN];
  assign sync_serial2_irq_en = en_q[1][`PIEB_SYNC_SERIAL2_IRQ_EN];
  assign bus_collision2_irq_en = en_q[1][`PIEB_BUS_COLLISION2_IRQ_EN];
  assign bus_collision1_irq_en = en_q[1][`PIEB_BUS_COLLISION1_IRQ_EN];
  assign voltage_detect_irq_en = en_q[1][`PIEB_VOLTAGE_DETECT_IRQ_EN];
  assign timer3_overflow_irq_en = en_q[1][`PIEB_TIMER3_OVERFLOW_IRQ_EN];
  assign timer3_gate_irq_en = en_q[1][`PIEB_TIMER3_GATE_IRQ_EN];
  // Register three; bit 6 has no storage
  assign timer5_gate_irq_en = en_q[2][`PIEB_TIMER5_GATE_IRQ_EN];
  assign serial2_rx_irq_en = en_q[2][`PIEB_SERIAL2_RX_IRQ_EN];
  assign serial2_tx_irq_en = en_q[2][`PIEB_SERIAL2_TX_IRQ_EN];
  assign charge_time_irq_en = en_q[2][`PIEB_CHARGE_TIME_IRQ_EN];
  assign capcomp2_irq_en = en_q[2][`PIEB_CAPCOMP2_IRQ_EN];
  assign capcomp1_irq_en = en_q[2][`PIEB_CAPCOMP1_IRQ_EN];
  assign rtc_irq_en = en_q[2][`PIEB_RTC_IRQ_EN];
  // Register four: capture/compare 10 at bit 7 down to 3 at bit 0
  assign capcomp_10_to_3_irq_en = en_q[3];
  // Register five
  assign timer7_gate_irq_en = en_q[4][`PIEB_TIMER7_GATE_IRQ_EN];
  assign timer12_match_irq_en = en_q[4][`PIEB_TIMER12_MATCH_IRQ_EN];
  assign timer10_match_irq_en = en_q[4][`PIEB_TIMER10_MATCH_IRQ_EN];
  assign timer8_match_irq_en = en_q[4][`PIEB_TIMER8_MATCH_IRQ_EN];
  assign timer7_overflow_irq_en = en_q[4][`PIEB_TIMER7_OVERFLOW_IRQ_EN];
  assign timer6_match_irq_en = en_q[4][`PIEB_TIMER6_MATCH_IRQ_EN];
  assign timer5_overflow_irq_en = en_q[4][`PIEB_TIMER5_OVERFLOW_IRQ_EN];
  assign timer4_match_irq_en = en_q[4][`PIEB_TIMER4_MATCH_IRQ_EN];

  // Enables back in flag order, bit 7 down to bit 0 of each byte.
  // Picked by position, put back by order: a slip shows as a dead source
  always_comb begin
    en_vec[7:0]   = {parallel_port_irq_en,
                     adc_done_irq_en,
                     serial1_rx_irq_en,
                     serial1_tx_irq_en,
                     sync_serial1_irq_en,
                     timer1_gate_irq_en,
                     timer2_match_irq_en,
                     timer1_overflow_irq_en};
    en_vec[15:8]  = {osc_fail_irq_en,
                     1'b0,
                     sync_serial2_irq_en,
                     bus_collision2_irq_en,
                     bus_collision1_irq_en,
                     voltage_detect_irq_en,
                     timer3_overflow_irq_en,
                     timer3_gate_irq_en};
    en_vec[23:16] = {timer5_gate_irq_en,
                     1'b0,
                     serial2_rx_irq_en,
                     serial2_tx_irq_en,
                     charge_time_irq_en,
                     capcomp2_irq_en,
                     capcomp1_irq_en,
                     rtc_irq_en};
    en_vec[31:24] = capcomp_10_to_3_irq_en;
    en_vec[39:32] = {timer7_gate_irq_en,
                     timer12_match_irq_en,
                     timer10_match_irq_en,
                     timer8_match_irq_en,
                     timer7_overflow_irq_en,
                     timer6_match_irq_en,
                     timer5_overflow_irq_en,
                     timer4_match_irq_en};
  end

  // Control register: group enable and priority mode
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      ctrl_q <= `PIEB_RST_CTRL;
    end else if (wr_i && addr_i == `PIEB_OFF_CTRL) begin
      ctrl_q <= wdata_i & (8'h01 << `PIEB_PERIPHERAL_GROUP_IRQ_EN
                          | 8'h01 << `PIEB_IRQ_PRIORITY_ENABLE);
    end
  end

  // Group enable only matters while priority mode is off
  assign group_ok = ctrl_q[`PIEB_IRQ_PRIORITY_ENABLE]
                  | ctrl_q[`PIEB_PERIPHERAL_GROUP_IRQ_EN];

  // Registered request outputs, one cycle behind the flags
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      gated_q  <= 40'h00_0000_0000;
      periph_q <= 1'b0;
    end else begin
      gated_q  <= gated_d;
      periph_q <= (|gated_d) & group_ok;
    end
  end

  assign gated_o      = gated_q;
  assign periph_irq_o = periph_q;

  // Write-one-to-clear of status bits
  always_comb begin
    stat_clr = `PIEB_RST_BANK;
    if (wr_i && addr_i == `PIEB_OFF_STAT) begin
      stat_clr = wdata_i[4:0];
    end
  end

  // Sticky status; a bank hit in the clearing cycle keeps the bit set
  always_comb begin
    stat_d = (stat_q & ~stat_clr) | bank_hit;
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      stat_q <= `PIEB_RST_BANK;
    end else begin
      stat_q <= stat_d;
    end
  end

  // Mask register of the same layout as status
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      mask_q <= `PIEB_RST_BANK;
    end else if (wr_i && addr_i == `PIEB_OFF_MASK) begin
      mask_q <= wdata_i[4:0];
    end
  end

  // Level interrupt; not gated by the group enable on purpose,
  // so software can poll banks with the core path closed
  assign irq_o = |(stat_q & mask_q);

  // Read mux; unmapped offsets read zero
  always_comb begin
    rdata_d = 8'h00;
    unique case (addr_i)
      `PIEB_OFF_EN1:  rdata_d = en_q[0] & impl_mask(0, PROG_MEM_32K);
      `PIEB_OFF_EN2:  rdata_d = en_q[1] & impl_mask(1, PROG_MEM_32K);
      `PIEB_OFF_EN3:  rdata_d = en_q[2] & impl_mask(2, PROG_MEM_32K);
      `PIEB_OFF_EN4:  rdata_d = en_q[3] & impl_mask(3, PROG_MEM_32K);
      `PIEB_OFF_EN5:  rdata_d = en_q[4] & impl_mask(4, PROG_MEM_32K);
      `PIEB_OFF_CTRL: rdata_d = ctrl_q;
      `PIEB_OFF_STAT: rdata_d = {3'h0, stat_q};
      `PIEB_OFF_MASK: rdata_d = {3'h0, mask_q};
      default:        rdata_d = 8'h00;
    endcase
  end

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      rdata_q <= 8'h00;
    end else if (rd_i) begin
      rdata_q <= rdata_d;
    end else begin
      rdata_q <= 8'h00;
    end
  end

  assign rdata_o = rdata_q;

endmodule : pieb_bank

// *** test/pieb_props.sv ***
`timescale 1ns/100ps
`include "pieb_regs.svh"
module pieb_props #(parameter bit PROG_MEM_32K = 1'b0) (
  // Clock, reset and register port
  input wire logic                 clk_i,
  input wire logic                 sys_rst_i,
  input wire pieb_pkg::pieb_addr_t addr_i,
  input wire pieb_pkg::pieb_byte_t wdata_i,
  input wire logic                 wr_i,
  input wire logic                 rd_i,
  input wire pieb_pkg::pieb_byte_t rdata_o,
  // Flags and requests
  input wire logic [39:0]          flags_i,
  input wire logic [39:0]          gated_o,
  input wire logic                 periph_irq_o,
  input wire logic                 irq_o
);
  // Bits that exist; the small variant loses six of them
  localparam logic [39:0] IMPL = PROG_MEM_32K ?
    {`PIEB_IMPL_EN5_32K, `PIEB_IMPL_EN4_32K, `PIEB_IMPL_EN3,
     `PIEB_IMPL_EN2, `PIEB_IMPL_EN1} :
    {`PIEB_IMPL_EN5, `PIEB_IMPL_EN4, `PIEB_IMPL_EN3,
     `PIEB_IMPL_EN2, `PIEB_IMPL_EN1};
  default clocking @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  // Requests and the bank interrupt all quiet straight after reset
  a_reset_quiet: assert property (
    $past(sys_rst_i) |-> gated_o == 40'h0 && !periph_irq_o && !irq_o)
    else $error("outputs not quiet after reset");
  a_gate_subset: assert property (
    (gated_o & ~$past(flags_i)) == 40'h0)
    else $error("request without its flag");
  a_gate_impl: assert property (
    (gated_o & ~IMPL) == 40'h0)
    else $error("request from a missing enable bit");
  a_req_or: assert property (
    periph_irq_o |-> |gated_o)
    else $error("core request with no gated source");
  a_bit6_read: assert property (
    $past(rd_i) && ($past(addr_i) == 4'h1 || $past(addr_i) == 4'h2)
    |-> !rdata_o[6])
    else $error("bit 6 read back as one");
  a_read_impl: assert property (
    $past(rd_i) && $past(addr_i) < 4'h5
    |-> (rdata_o & ~8'(IMPL >> {$past(addr_i), 3'h0})) == 8'h00)
    else $error("missing enable bit read back as one");
  // Zeroed enable blocks its byte two edges later
  a_write_gate: assert property (
    $past(wr_i, 2) && $past(addr_i, 2) < 4'h5 && $past(wdata_i, 2) == 8'h00
    |-> 8'(gated_o >> {$past(addr_i, 2), 3'h0}) == 8'h00)
    else $error("disabled byte still requests");
  a_group_gate: assert property (
    $past(wr_i, 2) && $past(addr_i, 2) == `PIEB_OFF_CTRL &&
    $past(wdata_i, 2) == 8'h00 && !$past(wr_i) |-> !periph_irq_o)
    else $error("core request with group enable off");
endmodule : pieb_props
bind pieb_bank pieb_props #(.PROG_MEM_32K(PROG_MEM_32K)) pieb_props_i (
  .clk_i(clk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
  .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .flags_i(flags_i),
  .gated_o(gated_o), .periph_irq_o(periph_irq_o), .irq_o(irq_o));

// *** test/pieb_src.sv ***
`timescale 1ns/100ps
// Flag sources: a flag stays set until software clears it
module pieb_src (
  // Clock and load command
  input  wire logic        clk_i,
  input  wire logic        load_i,
  input  wire logic [39:0] val_i,
  // Flag levels toward the bank
  output logic      [39:0] flags_o = 40'h0
);
  // Level flags, so an unserviced source keeps requesting
  always_ff @(posedge clk_i) begin
    if (load_i) flags_o <= val_i;
  end
endmodule : pieb_src

// *** test/tb.sv ***
`timescale 1ns/100ps
`include "pieb_regs.svh"
module tb;
  logic                 clk_i = 1'b0;
  logic                 sys_rst_i = 1'b1;
  pieb_pkg::pieb_addr_t addr_i = 4'h0;
  pieb_pkg::pieb_byte_t wdata_i = 8'h00;
  logic                 wr_i = 1'b0;
  logic                 rd_i = 1'b0;
  logic                 src_load = 1'b0;
  logic [39:0]          src_val = 40'h0;
  pieb_pkg::pieb_byte_t rdata_o;
  logic [39:0]          flags;
  logic [39:0]          gated_o;
  logic                 periph_irq_o;
  logic                 irq_o;
  int                   n_fail = 0;
  int                   samples_checked = 0;
  localparam logic [39:0] IMPL = {`PIEB_IMPL_EN5, `PIEB_IMPL_EN4,
    `PIEB_IMPL_EN3, `PIEB_IMPL_EN2, `PIEB_IMPL_EN1};
  always #4 clk_i = ~clk_i;
  pieb_bank pieb_bank_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .flags_i(flags), .gated_o(gated_o),
    .periph_irq_o(periph_irq_o), .irq_o(irq_o));
  pieb_src pieb_src_i (.clk_i(clk_i), .load_i(src_load), .val_i(src_val),
    .flags_o(flags));
  task automatic check(input logic [39:0] got, input logic [39:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  // Single-cycle strobes; #1 lets the register update land
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [7:0] exp);
    @(posedge clk_i);
    addr_i <= a;
    rd_i   <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 check(40'(rdata_o), 40'(exp));
  endtask : rd
  // Sources change, then one edge for the gated copy
  task automatic set_flags(input logic [39:0] v);
    @(posedge clk_i);
    src_load <= 1'b1;
    src_val  <= v;
    @(posedge clk_i);
    src_load <= 1'b0;
    @(posedge clk_i);
    #1;
  endtask : set_flags
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : report_and_stop
  // Tests take well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk_i);
    n_fail++;
    report_and_stop();
  end
  initial begin
    repeat (4) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    for (int a = 0; a < 9; a++) rd(4'(a), 8'h00);
    $display("reset values done");
    for (int a = 0; a < 5; a++) wr(4'(a), 8'hff);
    wr(4'h8, 8'hff);
    for (int a = 0; a < 5; a++) rd(4'(a), IMPL[a*8 +: 8]);
    rd(4'h8, 8'h00);
    $display("register access done");
    wr(`PIEB_OFF_CTRL, 8'h01);
    for (int i = 0; i < 40; i++) begin
      set_flags(40'h1 << i);
      check(gated_o, IMPL & (40'h1 << i));
      check(40'(periph_irq_o), 40'(IMPL[i]));
    end
    $display("source mapping done");
    wr(`PIEB_OFF_CTRL, 8'h00);
    set_flags(40'h1);
    check(40'(periph_irq_o), 40'h0);
    wr(`PIEB_OFF_CTRL, 8'h80);
    rd(`PIEB_OFF_CTRL, 8'h80);
    check(40'(periph_irq_o), 40'h1);
    $display("group enable done");
    check(40'(irq_o), 40'h0);
    rd(`PIEB_OFF_STAT, 8'h1f);
    wr(`PIEB_OFF_MASK, 8'h04);
    check(40'(irq_o), 40'h1);
    set_flags('1);
    for (int a = 0; a < 5; a++) wr(4'(a), 8'h00);
    @(posedge clk_i);
    #1 check(gated_o, 40'h0);
    wr(`PIEB_OFF_STAT, 8'h1b);
    rd(`PIEB_OFF_STAT, 8'h04);
    wr(`PIEB_OFF_STAT, 8'h04);
    check(40'(irq_o), 40'h0);
    $display("interrupt done");
    report_and_stop();
  end
endmodule : tb
